// *** rtl/urx_err_irq.v ***
/*
 * Receive error flags, interrupt combining, address qualification and
 * clock-off wake-up control of a UART, with an APB register slave.
 * Assumes the receive shifter presents a frame on frame_valid together
 * with its data and sampled error levels, and that the transmitter
 * supplies its two status levels. rx_pin is asynchronous.
 */
`timescale 1ns/1ps
`default_nettype none
`include "urx_defines.vh"

module urx_err_irq #(
	parameter STARTUP_CYC = `URX_STARTUP_CYC
) (
	input  wire        core_clk,
	input  wire        rst,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	// Receive shifter frame handoff
	input  wire        frame_valid,
	input  wire [8:0]  frame_data,
	input  wire        frame_noise,
	input  wire        frame_stop1_low,
	input  wire        frame_stop2_low,
	input  wire        frame_parity_bit,
	input  wire        rx_busy,
	// Transmitter status levels
	input  wire        tx_empty,
	input  wire        tx_idle,
	// Power and stack
	input  wire        stack_full,
	input  wire        rx_pin,
	// Outputs
	output wire        clk_run,
	output wire        link_hold,
	output reg         wake_req,
	output reg         irq_req_n,
	output reg         irq_service
);

	localparam CNT_W = 16;

	// Power states
	localparam PS_RUN   = 2'd0;
	localparam PS_OFF   = 2'd1;
	localparam PS_START = 2'd2;

	reg  [7:0]       ctrl_a_r;
	reg  [7:0]       ctrl_b_r;
	reg  [7:0]       baud_r;
	reg  [2:0]       sys_r;
	reg  [8:0]       data_r;
	reg              rxav_r;
	reg              nf_r;
	reg              ferr_r;
	reg              perr_r;
	reg              oerr_r;
	reg              st_read_r;
	reg  [1:0]       ps_r;
	reg  [CNT_W-1:0] su_cnt_r;
	reg              rx_s1_r;
	reg              rx_s2_r;
	reg              rx_s3_r;
	reg              wake_pend_r;
	reg              addr_pulse_r;
	reg              rxav_pulse_r;
	reg              oerr_pulse_r;
	reg              wake_pulse_r;

	wire acc      = psel & penable;
	wire wr       = acc & pwrite;
	wire rd       = acc & ~pwrite;
	wire st_rd    = rd & (paddr == `URX_OFS_STATUS);
	wire data_rd  = rd & (paddr == `URX_OFS_DATA);
	wire nine     = ctrl_a_r[`URX_CA_NINE];
	wire pren     = ctrl_a_r[`URX_CA_PREN];
	wire addden   = ctrl_b_r[`URX_CB_ADDEN];
	wire rie      = ctrl_b_r[`URX_CB_RIE];
	wire gie      = sys_r[`URX_SY_GIE];
	wire sie      = sys_r[`URX_SY_SIE];
	wire clk_off  = sys_r[`URX_SY_CLKOFF];
	wire running  = (ps_r == PS_RUN);
	wire mapped;

	// Frames accepted only in normal run
	wire take     = frame_valid & running;
	// Two-stop configuration checks the second stop bit too
	wire ferr_in  = frame_stop1_low |
		(ctrl_a_r[`URX_CA_STOP2] & frame_stop2_low);
	// Parity over data bits plus parity bit, odd type when set
	wire [7:0] pdata = nine ? frame_data[7:0] : {1'b0, frame_data[6:0]};
	wire pcalc    = ^pdata ^ frame_parity_bit ^ ctrl_a_r[`URX_CA_PRT];
	wire perr_in  = pren & pcalc;
	wire top_bit  = nine ? frame_data[8] : frame_data[7];
	// Overrun: new frame while buffer still full
	wire ovr      = take & rxav_r;
	// Clear sequence: status read then data read
	wire clr_seq  = data_rd & st_read_r;

	// Zero-wait slave; unmapped offsets answer with an error
	assign pready  = 1'b1;
	assign mapped  = (paddr == `URX_OFS_STATUS) |
		(paddr == `URX_OFS_CTRL_A) | (paddr == `URX_OFS_CTRL_B) |
		(paddr == `URX_OFS_DATA) | (paddr == `URX_OFS_BAUD) |
		(paddr == `URX_OFS_SYS);
	assign pslverr = acc & ~mapped;
	// Clock gate freezes shifter state rather than resetting it
	assign clk_run   = running & ~clk_off;
	assign link_hold = ~clk_run;

	// Rx pin synchroniser plus edge history
	always @(posedge core_clk) begin
		if (rst) begin
			rx_s1_r <= 1'b1;
			rx_s2_r <= 1'b1;
			rx_s3_r <= 1'b1;
		end else begin
			rx_s1_r <= rx_pin;
			rx_s2_r <= rx_s1_r;
			rx_s3_r <= rx_s2_r;
		end
	end

	// Falling edge taken from the synchronised pair only
	wire rx_fall = rx_s3_r & ~rx_s2_r;
	// Wake needs every receive enable in place
	wire wake_ok = ctrl_b_r[`URX_CB_WAKE] & ctrl_a_r[`URX_CA_MODE] &
		ctrl_a_r[`URX_CA_UEN] & ctrl_b_r[`URX_CB_RXEN] & rie;

	// Software registers; only the clock-off bit changes with power state, cleared at the end of start-up
	always @(posedge core_clk) begin
		if (rst) begin
			ctrl_a_r <= `URX_RST_CTRL;
			ctrl_b_r <= `URX_RST_CTRL;
			baud_r   <= `URX_RST_BAUD;
			sys_r    <= 3'b000;
		end else if (wr) begin
			case (paddr)
			`URX_OFS_CTRL_A: ctrl_a_r <= pwdata[7:0];
			`URX_OFS_CTRL_B: ctrl_b_r <= pwdata[7:0];
			`URX_OFS_BAUD:   baud_r   <= pwdata[7:0];
			`URX_OFS_SYS:    sys_r    <= pwdata[2:0];
			default:         ;
			endcase
		end else if (ps_r == PS_START && su_cnt_r == {CNT_W{1'b0}}) begin
			sys_r[`URX_SY_CLKOFF] <= 1'b0; // Clock restored on wake
		end
	end

	// Power sequencing: run, clock off, start-up count
	always @(posedge core_clk) begin
		if (rst) begin
			ps_r      <= PS_RUN;
			su_cnt_r  <= {CNT_W{1'b0}};
			wake_req  <= 1'b0;
		end else begin
			wake_req <= 1'b0;
			case (ps_r)
			PS_RUN: begin
				if (clk_off)
					ps_r <= PS_OFF;
			end
			PS_OFF: begin
				if (!clk_off) begin
					ps_r <= PS_RUN;
				end else if (rx_fall && wake_ok) begin
					wake_req <= 1'b1;
					su_cnt_r <= STARTUP_CYC[CNT_W-1:0];
					ps_r     <= PS_START;
				end
			end
			PS_START: begin
				// Count down, then release the clock gate
				if (su_cnt_r == {CNT_W{1'b0}})
					ps_r <= PS_RUN;
				else
					su_cnt_r <= su_cnt_r - 1'b1;
			end
			default: ps_r <= PS_RUN;
			endcase
		end
	end

	// Wake interrupt held pending until start-up ends
	always @(posedge core_clk) begin
		if (rst) begin
			wake_pend_r <= 1'b0;
		end else if (ps_r == PS_OFF && !clk_off) begin
			wake_pend_r <= 1'b0;
		end else if (ps_r == PS_OFF && rx_fall && wake_ok) begin
			wake_pend_r <= 1'b1;
		end else if (ps_r == PS_START && su_cnt_r == {CNT_W{1'b0}}) begin
			wake_pend_r <= 1'b0;
		end
	end

	// Status-read latch, consumed by the following data read
	always @(posedge core_clk) begin
		if (rst)
			st_read_r <= 1'b0;
		else if (st_rd)
			st_read_r <= 1'b1;
		else if (data_rd)
			st_read_r <= 1'b0;
	end

	// Data buffer and sticky flags; a new event beats a clear
	always @(posedge core_clk) begin
		if (rst) begin
			data_r <= 9'h000;
			rxav_r <= 1'b0;
			nf_r   <= 1'b0;
			ferr_r <= 1'b0;
			perr_r <= 1'b0;
			oerr_r <= 1'b0;
		end else if (take && !rxav_r) begin
			data_r <= frame_data;
			rxav_r <= 1'b1;
			nf_r   <= frame_noise;
			ferr_r <= ferr_in;
			perr_r <= perr_in;
		end else if (ovr) begin
			// Set wins over a clear in the same cycle
			oerr_r <= 1'b1;
			if (clr_seq) begin
				rxav_r <= 1'b0;
				nf_r   <= 1'b0;
				ferr_r <= 1'b0;
				perr_r <= 1'b0;
			end
		end else if (clr_seq) begin
			rxav_r <= 1'b0;
			nf_r   <= 1'b0;
			ferr_r <= 1'b0;
			perr_r <= 1'b0;
			oerr_r <= 1'b0;
		end
	end

	// One-cycle interrupt sources
	always @(posedge core_clk) begin
		if (rst) begin
			rxav_pulse_r <= 1'b0;
			addr_pulse_r <= 1'b0;
			oerr_pulse_r <= 1'b0;
			wake_pulse_r <= 1'b0;
		end else begin
			rxav_pulse_r <= take & ~rxav_r & (~addden | top_bit);
			addr_pulse_r <= take & ~rxav_r & addden & top_bit;
			oerr_pulse_r <= ovr;
			wake_pulse_r <= wake_pend_r & (ps_r == PS_START) &
				(su_cnt_r == {CNT_W{1'b0}});
		end
	end

	// Merge six sources into one low pulse; tx levels count on their rise
	reg  tx_src_r;
	wire tx_src   = (ctrl_b_r[`URX_CB_TEIE] & tx_empty) |
		(ctrl_b_r[`URX_CB_TIIE] & tx_idle);
	wire tx_rise  = tx_src & ~tx_src_r;
	wire rx_src   = rie & (rxav_pulse_r | oerr_pulse_r);
	wire any_src  = tx_rise | rx_src | addr_pulse_r | wake_pulse_r;

	// Service follows the same pulse, so a held tx level is taken once
	always @(posedge core_clk) begin
		if (rst) begin
			tx_src_r    <= 1'b0;
			irq_req_n   <= 1'b1;
			irq_service <= 1'b0;
		end else begin
			tx_src_r    <= tx_src;
			irq_req_n   <= ~any_src;
			irq_service <= any_src & gie & sie & ~stack_full & running;
		end
	end

	// Status word assembled from its field positions
	reg  [7:0] status_w;
	always @* begin
		status_w                  = 8'h00;
		status_w[`URX_ST_PERR]    = perr_r;
		status_w[`URX_ST_NF]      = nf_r;
		status_w[`URX_ST_FERR]    = ferr_r;
		status_w[`URX_ST_OERR]    = oerr_r;
		status_w[`URX_ST_RIDLE]   = ~rx_busy;
		status_w[`URX_ST_RXAV]    = rxav_r;
		status_w[`URX_ST_TIDLE]   = tx_idle;
		status_w[`URX_ST_TXEMPTY] = tx_empty;
	end

	// APB read mux, registered data
	always @(posedge core_clk) begin
		if (rst) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
			`URX_OFS_STATUS: prdata <= {24'h000000, status_w};
			`URX_OFS_CTRL_A: prdata <= {24'h000000, ctrl_a_r[7:1], data_r[8]};
			`URX_OFS_CTRL_B: prdata <= {24'h000000, ctrl_b_r};
			`URX_OFS_DATA:   prdata <= {24'h000000, data_r[7:0]};
			`URX_OFS_BAUD:   prdata <= {24'h000000, baud_r};
			`URX_OFS_SYS:    prdata <= {29'h00000000, sys_r};
			default:         prdata <= 32'h00000000;
			endcase
		end
	end

endmodule
`default_nettype wire

// *** rtl/urx_defines.vh ***
/*
 * Shared constants of the receive error / interrupt / wake-up block:
 * APB register offsets, field positions, reset values and timing counts.
 * Assumes inclusion by bare name from rtl/ design files.
 */
`ifndef URX_DEFINES_VH
`define URX_DEFINES_VH

// Register byte offsets on APB
`define URX_OFS_STATUS   12'h000
`define URX_OFS_CTRL_A   12'h004
`define URX_OFS_CTRL_B   12'h008
`define URX_OFS_DATA     12'h00C
`define URX_OFS_BAUD     12'h010
`define URX_OFS_SYS      12'h014

// Status register fields
`define URX_ST_PERR      0
`define URX_ST_NF        1
`define URX_ST_FERR      2
`define URX_ST_OERR      3
`define URX_ST_RIDLE     4
`define URX_ST_RXAV      5
`define URX_ST_TIDLE     6
`define URX_ST_TXEMPTY   7

// Control register A fields
`define URX_CA_RX8       0
`define URX_CA_PRT       5
`define URX_CA_PREN      6
`define URX_CA_NINE      7
`define URX_CA_STOP2     3
`define URX_CA_UEN       2
`define URX_CA_MODE      1

// Control register B fields
`define URX_CB_TEIE      0
`define URX_CB_TIIE      1
`define URX_CB_RIE       2
`define URX_CB_WAKE      3
`define URX_CB_ADDEN     4
`define URX_CB_RXEN      5

// System register fields (global / interface enables, clock gate)
`define URX_SY_GIE       0
`define URX_SY_SIE       1
`define URX_SY_CLKOFF    2

// Reset values
`define URX_RST_CTRL     8'h00
`define URX_RST_BAUD     8'h00

// Start-up interval after wake-up
`define URX_STARTUP_NS   1000
`define URX_CLK_MHZ      200
`define URX_STARTUP_CYC  ((`URX_STARTUP_NS * `URX_CLK_MHZ) / 1000)

`endif

// *** sim/urx_err_irq_checker.sv ***
/* Port assertions for urx_err_irq.
   Bound into every instance; sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module urx_chk #(
	parameter STARTUP_CYC = 4
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic stack_full,
	input wire logic frame_valid,
	input wire logic clk_run,
	input wire logic link_hold,
	input wire logic wake_req,
	input wire logic irq_req_n,
	input wire logic irq_service
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// Request low for exactly one cycle
	sequence s_low_pulse;
		!irq_req_n ##1 irq_req_n;
	endsequence
	// Request line quiet for three cycles
	sequence s_quiet;
		irq_req_n [*3];
	endsequence
	a_req_pulse: assert property (
		$fell(irq_req_n) |-> s_low_pulse)
		else $error("request pulse too long");
	a_stack_block: assert property (
		stack_full [*3] |-> !irq_service)
		else $error("serviced with stack full");
	a_service_cause: assert property (
		irq_service |-> !irq_req_n)
		else $error("service without request");
	a_hold_start: assert property (
		wake_req |-> link_hold ##1 link_hold)
		else $error("link released inside start-up");
	a_wake_off: assert property (wake_req |-> $past(link_hold))
		else $error("wake while running");
	a_quiet_off: assert property (link_hold |-> irq_req_n)
		else $error("request while clock off");
	a_wake_delay: assert property (wake_req |=> s_quiet)
		else $error("request inside start-up");
	a_drop_frame: assert property (
		frame_valid && link_hold |=> s_quiet)
		else $error("frame taken while off");
endmodule
bind urx_err_irq urx_chk #(.STARTUP_CYC(STARTUP_CYC)) u_chk (
	.core_clk(core_clk),
	.rst(rst),
	.stack_full(stack_full),
	.frame_valid(frame_valid),
	.clk_run(clk_run),
	.link_hold(link_hold),
	.wake_req(wake_req),
	.irq_req_n(irq_req_n),
	.irq_service(irq_service)
);
`default_nettype wire

// *** sim/urx_remote.sv ***
/* Far-side station: hands over received words with their error
   levels and drives the RX pin, idle high. Uses the bench clock. */
`timescale 1ns/1ps
`default_nettype none
module urx_remote (
	input wire logic core_clk,
	output logic frame_valid,
	output logic [8:0] frame_data,
	output logic [3:0] frame_err,
	output logic rx_pin
);
	initial begin
		frame_valid = 1'b0;
		frame_data = 9'h000;
		frame_err = 4'h0;
		rx_pin = 1'b1;
	end
	// One word; err is noise, stop1 low, stop2 low, parity bit
	task send(input [8:0] d, input [3:0] e);
		@(posedge core_clk);
		frame_valid <= 1'b1;
		frame_data <= d;
		frame_err <= e;
		@(posedge core_clk);
		frame_valid <= 1'b0;
		frame_data <= ~d; // Released bus shows no stale word
		frame_err <= ~e;
	endtask
	// Start-bit edge, then back to idle
	task fall;
		@(posedge core_clk);
		rx_pin <= 1'b0;
		repeat (3) @(posedge core_clk);
		rx_pin <= 1'b1;
	endtask
endmodule
`default_nettype wire

// *** sim/uart_rx_error_irq_wakeup_test.sv ***
/* Self-checking bench for urx_err_irq over APB.
   Assumes the remote model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
`include "urx_defines.vh"
module uart_rx_error_irq_wakeup_test;
	logic core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, q, prdata;
	logic tx_empty = 0, tx_idle = 0, stack_full = 0, err;
	logic [8:0] adr [4] = '{9'h100, 9'h0FF, 9'h080, 9'h07F};
	wire pready, pslverr, frame_valid, rx_pin, clk_run, link_hold;
	wire wake_req, irq_req_n, irq_service;
	wire [8:0] frame_data;
	wire [3:0] fe;
	int miscompares = 0, n_tests = 0, n_irq = 0, n_svc = 0, n_wake = 0;
	int cyc = 0, bi = 0, bs = 0, i;
	always #2.5 core_clk = ~core_clk;
	urx_remote rm (.core_clk(core_clk), .frame_valid(frame_valid),
		.frame_data(frame_data), .frame_err(fe), .rx_pin(rx_pin));
	urx_err_irq #(.STARTUP_CYC(4)) dut (.core_clk(core_clk), .rst(rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .frame_valid(frame_valid),
		.frame_data(frame_data), .frame_noise(fe[3]),
		.frame_stop1_low(fe[2]), .frame_stop2_low(fe[1]),
		.frame_parity_bit(fe[0]), .rx_busy(1'b0), .tx_empty(tx_empty),
		.tx_idle(tx_idle), .stack_full(stack_full), .rx_pin(rx_pin),
		.clk_run(clk_run), .link_hold(link_hold), .wake_req(wake_req),
		.irq_req_n(irq_req_n), .irq_service(irq_service));
	task test_done;
		if (miscompares == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Event counters and hang limit
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		n_irq <= n_irq + (!rst && irq_req_n === 1'b0);
		n_svc <= n_svc + (!rst && irq_service === 1'b1);
		n_wake <= n_wake + (!rst && wake_req === 1'b1);
		if (cyc == 5000) begin
			miscompares++;
			test_done;
		end
	end
	task chk(input [31:0] g, e);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %0t got %h exp %h", $time, g, e);
		end
	endtask
	// One APB transfer, held until pready
	task apb(input w, input [11:0] a, input [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1)
			@(posedge core_clk);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input [11:0] a, input [31:0] d);
		apb(1'b1, a, d);
	endtask
	task rd(input [11:0] a, input [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	task take(input [31:0] s, d);
		rd(`URX_OFS_STATUS, s);
		rd(`URX_OFS_DATA, d);
	endtask
	task cnt(input [31:0] ei, es);
		chk(n_irq - bi, ei);
		chk(n_svc - bs, es);
		bi = n_irq;
		bs = n_svc;
	endtask
	task wake(input [31:0] sys);
		wr(`URX_OFS_SYS, sys);
		rm.send(9'h044, 4'h0);
		chk(link_hold, 1);
		rm.fall;
		for (i = 0; i < 50 && clk_run !== 1'b1; i++)
			@(posedge core_clk);
		chk(clk_run, 1);
		repeat (8) @(posedge core_clk);
	endtask
	initial begin
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		rd(`URX_OFS_STATUS, 32'h10);
		rd(12'h020, 32'h0);
		chk(err, 1);
		wr(`URX_OFS_BAUD, 32'h5A);
		wr(`URX_OFS_CTRL_A, 32'h06);
		wr(`URX_OFS_CTRL_B, 32'h24);
		wr(`URX_OFS_SYS, 32'h03);
		rm.send(9'h05A, 4'hA);
		wr(`URX_OFS_STATUS, 32'h0);
		take(32'h32, 32'h5A);
		rd(`URX_OFS_STATUS, 32'h10);
		cnt(1, 1);
		wr(`URX_OFS_CTRL_A, 32'h0E);
		for (i = 0; i < 2; i++) begin
			rm.send(9'h0A5, i ? 4'h2 : 4'h4);
			take(32'h34, 32'hA5);
		end
		for (i = 0; i < 3; i++) begin
			wr(`URX_OFS_CTRL_A, i == 0 ? 32'h06 : i == 1 ? 32'h46 : 32'h66);
			rm.send(9'h001, 4'h0);
			take(i == 1 ? 32'h31 : 32'h30, 32'h01);
		end
		cnt(5, 5);
		wr(`URX_OFS_CTRL_B, 32'h34);
		for (i = 0; i < 4; i++) begin
			wr(`URX_OFS_CTRL_A, i < 2 ? 32'h86 : 32'h06);
			rm.send(adr[i], 4'h0);
			take(32'h30, {24'h0, adr[i][7:0]});
			cnt(!i[0], !i[0]);
		end
		wr(`URX_OFS_CTRL_B, 32'h24);
		rm.send(9'h011, 4'h0);
		rm.send(9'h022, 4'h0);
		take(32'h38, 32'h11);
		rd(`URX_OFS_STATUS, 32'h10);
		cnt(2, 2);
		wr(`URX_OFS_CTRL_B, 32'h25);
		tx_idle <= 1'b1;
		repeat (6) @(posedge core_clk);
		cnt(0, 0);
		tx_empty <= 1'b1;
		repeat (6) @(posedge core_clk);
		cnt(1, 1);
		tx_empty <= 1'b0;
		tx_idle <= 1'b0;
		stack_full <= 1'b1;
		rm.send(9'h033, 4'h0);
		take(32'h30, 32'h33);
		cnt(1, 0);
		stack_full <= 1'b0;
		wr(`URX_OFS_CTRL_B, 32'h2C);
		wake(32'h07);
		cnt(1, 1);
		chk(n_wake, 1);
		rd(`URX_OFS_STATUS, 32'h10);
		rd(`URX_OFS_CTRL_A, 32'h06);
		rd(`URX_OFS_CTRL_B, 32'h2C);
		rd(`URX_OFS_BAUD, 32'h5A);
		rd(`URX_OFS_SYS, 32'h03);
		wake(32'h04);
		cnt(1, 0);
		chk(n_wake, 2);
		test_done;
	end
endmodule
`default_nettype wire
